// [hw/rotc_trim_ctrl.sv]
// Our own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
// Notes on behaviour
// - Sync source is either the sync input pin or the low-speed crystal.
// - Chosen edge polarity applied, then prescaler divides edges into pulses.
// - Writing 1 to sw_sync_pulse makes one pulse, ORed with external.
// - Trim counter is 16 bits, captured and reloaded on sync pulses.
// - Counter runs on oscillator clock; first pulse after enable starts down-count.
// - Every later pulse reloads reload_count and restarts the down-count.
// - Without pulses: down to zero, up to 128 x limit, then halt.
// - Each pulse after the first captures counter value and count direction into status.
// - Tolerance limit is an 8-bit base value.
// - Pulse on down-count means slow, raise trim; on up-count lower it.
// - Counter below limit: ok flag, trim unchanged.
// - Limit to 3 x limit: ok flag, trim +1 down or -1 up.
// - 3 x limit to 128 x limit: warn flag, trim +2 or -2.
// - Down-count pulse at or above 128 x limit: clock error, trim kept.
// - Up-count reaching 128 x limit: reference missing flag, trim kept.
// - Interrupts gated by ok, warn and shared error enables.
// - Trim saturates at 0 and 63 and sets trim range error.
// - Source code 00 is the pin, 01 the crystal, others reserved.
// - Writes to control register 1 ignored while counter enabled.
// - Trim code resets to midpoint 32; each step moves frequency one unit.
// - sw_sync_pulse clears itself and always reads zero.
module rotc_trim_ctrl
  import rotc_pkg::*;
(
  // Clock and reset; hclk is the oscillator clock being trimmed
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Reference sources
  input  wire logic        sync_input_pin,
  input  wire logic        low_speed_crystal,
  // Oscillator trim and interrupt requests
  output logic      [5:0]  trim_code,
  output logic             ok_irq,
  output logic             warn_irq,
  output logic             error_irq
);

  // Bus phase capture
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        addr_ok;
  logic        wr_ctl0, wr_ctl1, wr_clr;

  // Control state
  logic [5:0]  trim_q;
  logic        sw_sync_pulse_q;
  logic        hw_trim_mode_q;
  logic        trim_counter_enable_q;
  logic        ok_irq_enable_q, warn_irq_enable_q, error_irq_enable_q;
  logic [15:0] reload_count_q;
  logic [7:0]  tolerance_limit_q;
  logic [2:0]  ref_prescale_q;
  logic [1:0]  ref_source_select_q;
  logic        ref_edge_polarity_q;

  // Status
  logic        trim_ok_flag_q, trim_warn_flag_q, clock_error_flag_q;
  logic        ref_missing_flag_q, trim_range_error_flag_q;
  logic        error_irq_flag;
  logic [15:0] captured_count_q;
  logic        captured_direction_q;

  // Reference path
  logic        src_lvl, src_prev_q, src_edge, ext_pulse, sync_pulse;
  logic [6:0]  psc_cnt_q;
  logic [6:0]  psc_last;

  // Counter
  rotc_state_e state_q;
  logic [15:0] cnt_q;
  logic        up_q;
  logic [15:0] lim1, lim3, lim128;
  logic        ev_ok, ev_warn, ev_clock_error_flag, ev_miss;
  logic [1:0]  step;
  logic [6:0]  trim_sum;
  logic        trim_sat;

  assign addr_ok  = hsel && hready && htrans[1];
  assign wr_ctl0  = wr_pend_q && (wr_addr_q == ROTC_CTL0_OFS);
  assign wr_ctl1  = wr_pend_q && (wr_addr_q == ROTC_CTL1_OFS)
                    && !trim_counter_enable_q;
  assign wr_clr   = wr_pend_q && (wr_addr_q == ROTC_CLR_OFS);
  assign error_irq_flag = clock_error_flag_q || ref_missing_flag_q
                          || trim_range_error_flag_q;

  // Zero-wait slave, always OKAY; writes land at the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr;
    end
  end

  // Read data prepared at the address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= 32'h0000_0000;
      if (haddr == ROTC_CTL0_OFS) begin
        hrdata[ROTC_TRIM_LSB +: 6]  <= trim_q;
        hrdata[ROTC_HW_TRIM_BIT]    <= hw_trim_mode_q;
        hrdata[ROTC_CNT_EN_BIT]     <= trim_counter_enable_q;
        hrdata[ROTC_ERR_IE_BIT]     <= error_irq_enable_q;
        hrdata[ROTC_WARN_IE_BIT]    <= warn_irq_enable_q;
        hrdata[ROTC_OK_IE_BIT]      <= ok_irq_enable_q;
      end else if (haddr == ROTC_CTL1_OFS) begin
        hrdata[ROTC_POL_BIT]          <= ref_edge_polarity_q;
        hrdata[ROTC_SEL_LSB +: 2]     <= ref_source_select_q;
        hrdata[ROTC_PSC_LSB +: 3]     <= ref_prescale_q;
        hrdata[ROTC_LIMIT_LSB +: 8]   <= tolerance_limit_q;
        hrdata[ROTC_RELOAD_LSB +: 16] <= reload_count_q;
      end else if (haddr == ROTC_STAT_OFS) begin
        hrdata[ROTC_CAP_LSB +: 16] <= captured_count_q;
        hrdata[ROTC_DIR_BIT]       <= captured_direction_q;
        hrdata[ROTC_TRIM_RANGE_ERROR_FLAG_BIT]   <= trim_range_error_flag_q;
        hrdata[ROTC_MISS_BIT]      <= ref_missing_flag_q;
        hrdata[ROTC_CLOCK_ERROR_FLAG_BIT]     <= clock_error_flag_q;
        hrdata[ROTC_ERRIRQ_BIT]    <= error_irq_flag;
        hrdata[ROTC_WARN_BIT]      <= trim_warn_flag_q;
        hrdata[ROTC_OK_BIT]        <= trim_ok_flag_q;
      end
    end
  end

  // Control register 0 except trim code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hw_trim_mode_q        <= 1'b0;
      trim_counter_enable_q <= 1'b0;
      error_irq_enable_q    <= 1'b0;
      warn_irq_enable_q     <= 1'b0;
      ok_irq_enable_q       <= 1'b0;
      sw_sync_pulse_q       <= 1'b0;
    end else begin
      sw_sync_pulse_q <= wr_ctl0 && hwdata[ROTC_SW_SYNC_BIT];
      if (wr_ctl0) begin
        hw_trim_mode_q        <= hwdata[ROTC_HW_TRIM_BIT];
        trim_counter_enable_q <= hwdata[ROTC_CNT_EN_BIT];
        error_irq_enable_q    <= hwdata[ROTC_ERR_IE_BIT];
        warn_irq_enable_q     <= hwdata[ROTC_WARN_IE_BIT];
        ok_irq_enable_q       <= hwdata[ROTC_OK_IE_BIT];
      end
    end
  end

  // Control register 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_edge_polarity_q <= 1'b0;
      ref_source_select_q <= ROTC_SEL_RST;
      ref_prescale_q      <= 3'h0;
      tolerance_limit_q   <= ROTC_LIMIT_RST;
      reload_count_q      <= ROTC_RELOAD_RST;
    end else if (wr_ctl1) begin
      ref_edge_polarity_q <= hwdata[ROTC_POL_BIT];
      ref_source_select_q <= hwdata[ROTC_SEL_LSB +: 2];
      ref_prescale_q      <= hwdata[ROTC_PSC_LSB +: 3];
      tolerance_limit_q   <= hwdata[ROTC_LIMIT_LSB +: 8];
      reload_count_q      <= hwdata[ROTC_RELOAD_LSB +: 16];
    end
  end

  // Reference source, polarity and prescaler
  always_comb begin
    case (ref_source_select_q)
      ROTC_SRC_PIN:     src_lvl = sync_input_pin ^ ref_edge_polarity_q;
      ROTC_SRC_CRYSTAL: src_lvl = low_speed_crystal ^ ref_edge_polarity_q;
      default:          src_lvl = 1'b0;
    endcase
  end

  assign src_edge  = src_lvl && !src_prev_q;
  assign psc_last  = 7'((8'h01 << ref_prescale_q) - 8'h01);
  assign ext_pulse = src_edge && (psc_cnt_q == psc_last);
  assign sync_pulse = ext_pulse || sw_sync_pulse_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_prev_q <= 1'b0;
      psc_cnt_q  <= 7'h00;
    end else begin
      src_prev_q <= src_lvl;
      if (!trim_counter_enable_q) begin
        psc_cnt_q <= 7'h00;
      end else if (src_edge) begin
        psc_cnt_q <= ext_pulse ? 7'h00 : psc_cnt_q + 7'h01;
      end
    end
  end

  // Evaluation windows
  assign lim1   = {8'h00, tolerance_limit_q};
  assign lim3   = 16'(lim1 * ROTC_WARN_MULT);
  assign lim128 = 16'(lim1 * ROTC_MISS_MULT);

  always_comb begin
    ev_ok    = 1'b0;
    ev_warn  = 1'b0;
    ev_clock_error_flag = 1'b0;
    step     = 2'd0;
    if (sync_pulse && state_q != ROTC_IDLE && state_q != ROTC_WAIT) begin
      if (cnt_q < lim1) begin
        ev_ok = 1'b1;
      end else if (cnt_q < lim3) begin
        ev_ok = 1'b1;
        step  = 2'd1;
      end else if (cnt_q < lim128) begin
        ev_warn = 1'b1;
        step    = 2'd2;
      end else if (!up_q) begin
        ev_clock_error_flag = 1'b1;
      end
    end
  end

  assign ev_miss = (state_q == ROTC_RUN) && up_q && (cnt_q == lim128)
                   && !sync_pulse;

  // Trim adjust with saturation
  always_comb begin
    trim_sum = {1'b0, trim_q};
    trim_sat = 1'b0;
    if (hw_trim_mode_q && step != 2'd0) begin
      if (!up_q) begin
        trim_sum = {1'b0, trim_q} + {5'h00, step};
        if (trim_sum > ROTC_TRIM_MAX) begin
          trim_sum = ROTC_TRIM_MAX;
          trim_sat = 1'b1;
        end
      end else if ({1'b0, trim_q} < {5'h00, step}) begin
        trim_sum = 7'h00;
        trim_sat = 1'b1;
      end else begin
        trim_sum = {1'b0, trim_q} - {5'h00, step};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_q <= ROTC_TRIM_RST;
    end else if (hw_trim_mode_q) begin
      trim_q <= trim_sum[5:0];
    end else if (wr_ctl0) begin
      trim_q <= hwdata[ROTC_TRIM_LSB +: 6];
    end
  end

  // Trim counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ROTC_IDLE;
      cnt_q   <= 16'h0000;
      up_q    <= 1'b0;
    end else if (!trim_counter_enable_q) begin
      state_q <= ROTC_IDLE;
      up_q    <= 1'b0;
    end else begin
      case (state_q)
        ROTC_IDLE: state_q <= ROTC_WAIT;
        ROTC_WAIT: begin
          if (sync_pulse) begin
            state_q <= ROTC_RUN;
            cnt_q   <= reload_count_q;
            up_q    <= 1'b0;
          end
        end
        ROTC_RUN, ROTC_HALT: begin
          if (sync_pulse) begin
            state_q <= ROTC_RUN;
            cnt_q   <= reload_count_q;
            up_q    <= 1'b0;
          end else if (state_q == ROTC_HALT || ev_miss) begin
            state_q <= ROTC_HALT;
          end else if (!up_q && cnt_q == 16'h0000) begin
            up_q  <= 1'b1;
            cnt_q <= 16'h0001;
          end else if (up_q) begin
            cnt_q <= cnt_q + 16'h0001;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: state_q <= ROTC_IDLE;
      endcase
    end
  end

  // Capture on every counted pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      captured_count_q     <= 16'h0000;
      captured_direction_q <= 1'b0;
    end else if (sync_pulse && (state_q == ROTC_RUN
                                || state_q == ROTC_HALT)) begin
      captured_count_q     <= cnt_q;
      captured_direction_q <= up_q;
    end
  end

  // Sticky flags; a set in the same cycle beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_ok_flag_q          <= 1'b0;
      trim_warn_flag_q        <= 1'b0;
      clock_error_flag_q      <= 1'b0;
      ref_missing_flag_q      <= 1'b0;
      trim_range_error_flag_q <= 1'b0;
    end else begin
      trim_ok_flag_q <= ev_ok ||
        (trim_ok_flag_q && !(wr_clr && hwdata[ROTC_OK_BIT]));
      trim_warn_flag_q <= ev_warn ||
        (trim_warn_flag_q && !(wr_clr && hwdata[ROTC_WARN_BIT]));
      clock_error_flag_q <= ev_clock_error_flag ||
        (clock_error_flag_q && !(wr_clr && (hwdata[ROTC_CLOCK_ERROR_FLAG_BIT]
                                 || hwdata[ROTC_ERRIRQ_BIT])));
      ref_missing_flag_q <= ev_miss ||
        (ref_missing_flag_q && !(wr_clr && (hwdata[ROTC_MISS_BIT]
                                 || hwdata[ROTC_ERRIRQ_BIT])));
      trim_range_error_flag_q <= trim_sat ||
        (trim_range_error_flag_q && !(wr_clr && (hwdata[ROTC_TRIM_RANGE_ERROR_FLAG_BIT]
                                      || hwdata[ROTC_ERRIRQ_BIT])));
    end
  end

  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trim_code <= ROTC_TRIM_RST;
      ok_irq    <= 1'b0;
      warn_irq  <= 1'b0;
      error_irq <= 1'b0;
    end else begin
      trim_code <= trim_q;
      ok_irq    <= trim_ok_flag_q && ok_irq_enable_q;
      warn_irq  <= trim_warn_flag_q && warn_irq_enable_q;
      error_irq <= error_irq_flag && error_irq_enable_q;
    end
  end

  // Unused bus inputs in this word-only slave
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize, htrans[0]};

endmodule

// [hw/rotc_pkg.sv]
package rotc_pkg;

  // Register byte offsets
  localparam logic [7:0] ROTC_CTL0_OFS = 8'h00;
  localparam logic [7:0] ROTC_CTL1_OFS = 8'h04;
  localparam logic [7:0] ROTC_STAT_OFS = 8'h08;
  localparam logic [7:0] ROTC_CLR_OFS  = 8'h0c;

  // Control register 0 fields
  localparam int ROTC_OK_IE_BIT   = 0;
  localparam int ROTC_WARN_IE_BIT = 1;
  localparam int ROTC_ERR_IE_BIT  = 2;
  localparam int ROTC_CNT_EN_BIT  = 5;
  localparam int ROTC_HW_TRIM_BIT = 6;
  localparam int ROTC_SW_SYNC_BIT = 7;
  localparam int ROTC_TRIM_LSB    = 8;

  // Control register 1 fields
  localparam int ROTC_RELOAD_LSB = 0;
  localparam int ROTC_LIMIT_LSB  = 16;
  localparam int ROTC_PSC_LSB    = 24;
  localparam int ROTC_SEL_LSB    = 28;
  localparam int ROTC_POL_BIT    = 31;

  // Status and clear register fields
  localparam int ROTC_OK_BIT      = 0;
  localparam int ROTC_WARN_BIT    = 1;
  localparam int ROTC_ERRIRQ_BIT  = 2;
  localparam int ROTC_CLOCK_ERROR_FLAG_BIT   = 8;
  localparam int ROTC_MISS_BIT    = 9;
  localparam int ROTC_TRIM_RANGE_ERROR_FLAG_BIT = 10;
  localparam int ROTC_DIR_BIT     = 15;
  localparam int ROTC_CAP_LSB     = 16;

  // Reset values
  localparam logic [5:0]  ROTC_TRIM_RST   = 6'h20;
  localparam logic [15:0] ROTC_RELOAD_RST = 16'hbb7f;
  localparam logic [7:0]  ROTC_LIMIT_RST  = 8'h22;
  // Source select wakes on a reserved code: no reference until chosen
  localparam logic [1:0]  ROTC_SEL_RST    = 2'b10;

  // Trim code range and evaluation factors
  localparam logic [6:0] ROTC_TRIM_MAX  = 7'h3f;
  localparam int         ROTC_MISS_MULT = 128;
  localparam int         ROTC_WARN_MULT = 3;

  typedef enum logic [1:0] {
    ROTC_SRC_PIN     = 2'b00,
    ROTC_SRC_CRYSTAL = 2'b01
  } rotc_src_e;

  typedef enum logic [1:0] {
    ROTC_IDLE = 2'b00,
    ROTC_WAIT = 2'b01,
    ROTC_RUN  = 2'b10,
    ROTC_HALT = 2'b11
  } rotc_state_e;

endpackage

// [test/rotc_trim_ctrl_assertions.sv]
`timescale 1ns/100ps
module rotc_trim_ctrl_assertions
  import rotc_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Reference, trim and requests
  input wire logic        sync_input_pin,
  input wire logic        low_speed_crystal,
  input wire logic [5:0]  trim_code,
  input wire logic        ok_irq,
  input wire logic        warn_irq,
  input wire logic        error_irq
);
  logic        wr_a;
  logic        rd_a;
  logic        wr_dp_q;
  logic [3:0]  wr_hist_q;
  logic [31:0] ctl0_q;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  assign wr_a = hsel && hready && htrans[1] && hwrite;
  assign rd_a = hsel && hready && htrans[1] && !hwrite;

  // Shadow of control register 0 and recent software writes to it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_hist_q <= 4'h0;
      wr_dp_q   <= 1'b0;
      ctl0_q    <= 32'h2000;
    end else begin
      wr_hist_q <= {wr_hist_q[2:0], wr_a && haddr == ROTC_CTL0_OFS};
      wr_dp_q   <= wr_a && haddr == ROTC_CTL0_OFS;
      if (wr_dp_q) ctl0_q <= hwdata;
    end
  end

  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus slave stalled or answered with an error");
  property p_trim_step;
    trim_code != $past(trim_code) && wr_hist_q == 4'h0 |->
      6'(trim_code - $past(trim_code)) inside {6'h01, 6'h02, 6'h3e, 6'h3f};
  endproperty
  a_trim_step: assert property (p_trim_step)
    else $error("trim code moved by more than two steps");
  property p_trim_hold;
    !ctl0_q[ROTC_HW_TRIM_BIT] && wr_hist_q == 4'h0 |-> $stable(trim_code);
  endproperty
  a_trim_hold: assert property (p_trim_hold)
    else $error("trim code moved outside hardware trim mode");
  property p_ok_gate;
    !$past(ctl0_q[ROTC_OK_IE_BIT]) |-> !ok_irq;
  endproperty
  a_ok_gate: assert property (p_ok_gate)
    else $error("ok request raised while disabled");
  property p_warn_gate;
    !$past(ctl0_q[ROTC_WARN_IE_BIT]) |-> !warn_irq;
  endproperty
  a_warn_gate: assert property (p_warn_gate)
    else $error("warning request raised while disabled");
  property p_err_gate;
    !$past(ctl0_q[ROTC_ERR_IE_BIT]) |-> !error_irq;
  endproperty
  a_err_gate: assert property (p_err_gate)
    else $error("error request raised while disabled");
  property p_sw_sync_zero;
    rd_a && haddr == ROTC_CTL0_OFS |=> !hrdata[ROTC_SW_SYNC_BIT];
  endproperty
  a_sw_sync_zero: assert property (p_sw_sync_zero)
    else $error("software sync bit read back as one");
  property p_unmapped_zero;
    rd_a && haddr[7:4] != 4'h0 |=> hrdata == 32'h0;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read returned nonzero data");

  c_trim_step: cover property (trim_code != $past(trim_code));
  c_warn_irq: cover property ($rose(warn_irq));
  c_err_irq: cover property ($rose(error_irq));
endmodule

// [test/rotc_ref_source.sv]
`timescale 1ns/100ps
module rotc_ref_source (
  // Clock and burst control
  input  wire logic        hclk,
  input  wire logic        start,
  input  wire logic        use_crystal,
  input  wire logic        invert,
  input  wire logic [15:0] period,
  input  wire logic [15:0] count,
  output logic             busy,
  // Reference lines
  output logic             sync_input_pin,
  output logic             low_speed_crystal
);
  logic [15:0] phase_q = 16'h0;
  logic [15:0] left_q  = 16'h0;
  logic        busy_q  = 1'b0;
  logic        noise_q = 1'b0;
  logic        lvl;

  always_ff @(posedge hclk) begin
    noise_q <= ~noise_q;
    if (start) begin
      busy_q  <= 1'b1;
      phase_q <= 16'h0;
      left_q  <= count;
    end else if (busy_q && phase_q == period - 16'h1) begin
      phase_q <= 16'h0;
      left_q  <= left_q - 16'h1;
      busy_q  <= left_q != 16'h1;
    end else if (busy_q) begin
      phase_q <= phase_q + 16'h1;
    end
  end

  // Unselected line toggles every cycle so only the chosen one may count
  assign lvl               = (busy_q && phase_q < 16'h4) ^ invert;
  assign busy              = busy_q;
  assign sync_input_pin    = use_crystal ? noise_q : lvl;
  assign low_speed_crystal = use_crystal ? lvl : noise_q;
endmodule

// [test/tb_rotc_trim_ctrl.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_rotc_trim_ctrl
  import rotc_pkg::*;
;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [7:0]  haddr = 8'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd, ctl1;
  logic        hreadyout, hresp, pin, xtal, ok_irq, warn_irq, error_irq;
  logic [5:0]  trim_code;
  logic        ps_go = 0, ps_busy, ps_xtal = 0, ps_inv = 0;
  logic [15:0] ps_per = 16'h10, ps_cnt = 16'h0;
  logic [2:0]  ie;
  int          n_errors = 0, cmp_count = 0, cyc = 0, seed = 1, st, tr, a;
  // Source, prescale, polarity, reload, limit, period, pulses, trim, hw;
  // reload and limit follow the period ratio
  int t[8][9] = '{'{1, 1, 0, 416, 8, 200, 6, 32, 1},
                  '{0, 0, 1, 300, 8, 200, 3, 32, 1},
                  '{0, 0, 0, 1300, 8, 200, 3, 32, 1},
                  '{0, 0, 0, 184, 8, 200, 3, 32, 1},
                  '{0, 0, 0, 100, 8, 200, 2, 1, 1},
                  '{0, 0, 0, 300, 8, 200, 2, 62, 1},
                  '{0, 0, 0, 300, 8, 200, 3, 40, 0},
                  '{0, 0, 0, 203, 8, 200, 3, 40, 1}};

  assign hready = hreadyout;
  always #20 hclk = ~hclk;

  rotc_trim_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
    .sync_input_pin(pin), .low_speed_crystal(xtal), .trim_code, .ok_irq,
    .warn_irq, .error_irq);
  rotc_ref_source u_ref (.hclk, .start(ps_go), .use_crystal(ps_xtal),
    .invert(ps_inv), .period(ps_per), .count(ps_cnt), .busy(ps_busy),
    .sync_input_pin(pin), .low_speed_crystal(xtal));

  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d);
  endtask
  task automatic rd_(input logic [7:0] ad);
    bus(1'b0, ad, 32'h0);
  endtask

  // Expected flags, trim and capture from the period to reload relation
  function automatic void model(int r);
    int c, d, dn, lim;
    lim = t[r][4];
    c = t[r][3] + 1 - (t[r][5] << t[r][1]);
    dn = c >= 0;
    a = dn ? c : -c;
    tr = t[r][7];
    st = dn ? 0 : 32'h8000;
    for (int e = 1; e < (t[r][6] >> t[r][1]); e++) begin
      d = a < lim ? 0 : a < 3 * lim ? 1 : a < 128 * lim ? 2 : 0;
      st |= a < 3 * lim ? 1 : a < 128 * lim ? 2 : 32'h104;
      if (t[r][8] == 1) tr += dn ? d : -d;
      if (tr > 63 || tr < 0) st |= 32'h404;
      tr = tr > 63 ? 63 : tr < 0 ? 0 : tr;
    end
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_(ROTC_CTL0_OFS); `CHK(rd, 32'h2000)
    rd_(ROTC_CTL1_OFS); `CHK(rd, 32'h2022bb7f)
    for (int r = 0; r < 8; r++) begin
      ie = 3'($random(seed));
      ctl1 = {1'(t[r][2]), 1'b0, 2'(t[r][0]), 1'b0, 3'(t[r][1]),
              8'(t[r][4]), 16'(t[r][3])};
      ps_xtal <= 1'(t[r][0]);
      ps_inv <= 1'(t[r][2]);
      ps_per <= 16'(t[r][5]);
      ps_cnt <= 16'(t[r][6]);
      wr(ROTC_CTL0_OFS, 32'h0);
      wr(ROTC_CLR_OFS, 32'h707);
      wr(ROTC_CTL1_OFS, ctl1);
      wr(ROTC_CTL0_OFS, {18'h0, 6'(t[r][7]), 8'h0});
      wr(ROTC_CTL0_OFS, {18'h0, 6'(t[r][7]), 1'b0, 1'(t[r][8]), 3'h4, ie});
      wr(ROTC_CTL1_OFS, ~ctl1);
      rd_(ROTC_CTL1_OFS); `CHK(rd, ctl1)
      ps_go <= 1'b1;
      @(posedge hclk);
      ps_go <= 1'b0;
      repeat (2) @(posedge hclk);
      while (ps_busy === 1'b1) @(posedge hclk);
      repeat (8) @(posedge hclk);
      model(r);
      rd_(ROTC_STAT_OFS); `CHK(rd & 32'h8707, 32'(st))
      `CHK(rd[31:16], 16'(a))
      rd_(ROTC_CTL0_OFS); `CHK(rd[13:7], {6'(tr), 1'b0})
      `CHK(trim_code, 6'(tr))
      `CHK({error_irq, warn_irq, ok_irq}, ie & 3'(st))
      $display("test %0d done", r);
    end
    wr(ROTC_CTL0_OFS, 32'h0);
    wr(ROTC_CLR_OFS, 32'h707);
    wr(ROTC_CTL1_OFS, {2'h0, 2'h2, 4'h0, 8'h1, 16'ha});
    wr(ROTC_CTL0_OFS, 32'h24);
    wr(ROTC_CTL0_OFS, 32'ha4);
    repeat (300) @(posedge hclk);
    rd_(ROTC_STAT_OFS); `CHK(rd & 32'h707, 32'h204)
    wr(ROTC_STAT_OFS, 32'h0);
    rd_(ROTC_STAT_OFS); `CHK(rd & 32'h707, 32'h204)
    `CHK(error_irq, 1'b1)
    rd_(8'h10); `CHK(rd, 32'h0)
    $display("test missing reference done");
    print_verdict();
  end
endmodule

bind rotc_trim_ctrl rotc_trim_ctrl_assertions u_chk (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout,
  .hresp, .sync_input_pin, .low_speed_crystal, .trim_code, .ok_irq,
  .warn_irq, .error_irq);
